// *** macra_core.sv ***
// Serial command decoder with the channel and global register file.
// Assumes sclk stands still while cs_n is high, and the host keeps cs_n
// high at least 4 clk cycles and low 3 clk cycles before the first sclk.
//
// Behaviour
// - Read-all ignores address, sends 20 bytes in channel order.
// - Read channel config sends upper, lower threshold, config byte.
// - Read global sends enable, input config, setup; address ignored.
// - Reset command restores power-on values and requests shutdown.
// - Clear-selected clears that channel's alarm bits and fault counter.
// - Clear-all-alarms clears every channel's alarm bits and fault counter.
// - Write-selected-data loads two bytes into the addressed data register.
// - Write-all-data loads every data register in channel order.
// - Write channel config stores upper, lower threshold, config byte.
// - Channel config write also clears that channel's alarm and counter.
// - Write global stores enable, input config, setup; address ignored.
// - Channel enables steer the automatic scan only, not manual conversions.
// - Enable bit set includes channel; bits 11..2 channels, 1..0 reserved.
// - Differential pairs disregard the odd input's enable bit.
// - After reset every channel enable bit is set.
// - Input configuration holds one 3-bit code per input pair.
// - After reset the input configuration register is all zeros.
// - Command word: upper nibble is command, lower nibble is channel address.
// - Addresses 0 and 1 are internal, 2 to 9 external, above reserved.
// - Input sampled on rising serial edges, output changes on falling edges.
// - Select high ends the frame, applies its command and idles the serial interface.
`timescale 1ns/1ps
`default_nettype none
module macra_core
  import macra_pkg::*;
#(
  parameter int THR_W = 16
) (
  // System clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  // Conversion results from the sequencer
  input wire logic conv_valid,
  input wire logic [3:0] conv_chan,
  input wire logic [DATA_W-1:0] conv_data,
  output logic conv_ready,
  // Per-channel lookup for the comparator
  input wire logic [3:0] look_chan,
  output logic [DATA_W-1:0] look_data,
  output logic [THR_W-1:0] look_thr_hi,
  output logic [THR_W-1:0] look_thr_lo,
  output logic [7:0] look_cfg,
  // Global configuration
  output logic [11:0] chan_enable,
  output logic [11:0] input_pair_cfg,
  output logic [11:0] scan_enable,
  output logic [7:0] setup_cfg,
  // Events to the alarm logic and power control
  output logic [N_CH-1:0] alarm_clr,
  output logic soft_reset,
  output logic shutdown_req
);
  generate
    if (THR_W < 1 || THR_W > 16) begin : g_chk
      $error("macra_core: THR_W must lie in 1..16");
    end
  endgenerate

  function automatic logic chan_ok(input logic [3:0] a);
    chan_ok = (a <= CH_LAST);
  endfunction

  // ---------------- Link domain (sclk) ----------------
  logic rst_link_n;
  logic [7:0] bits_reg;
  logic [6:0] shin_reg;
  logic [7:0] cmd_reg;
  logic [4:0] nbyte_reg;
  logic stage_tog_reg;
  logic [7:0] wbuf [WR_MAX];
  logic dout_reg;
  wire byte_done;
  wire [7:0] rx_byte;

  // Select high holds the bit-level logic idle
  assign rst_link_n = nrst & ~cs_n;
  assign byte_done = (bits_reg[2:0] == 3'h7) && (bits_reg != BIT_CNT_SAT);
  assign rx_byte = {shin_reg, din};

  always_ff @(posedge sclk or negedge rst_link_n) begin
    if (!rst_link_n) begin
      bits_reg <= 8'h00;
      shin_reg <= 7'h00;
    end else begin
      bits_reg <= (bits_reg == BIT_CNT_SAT) ? bits_reg : bits_reg + 8'h01;
      shin_reg <= {shin_reg[5:0], din};
    end
  end

  // Staging survives select high so the system side can apply it
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      cmd_reg <= 8'h00;
      nbyte_reg <= 5'h00;
      stage_tog_reg <= 1'b0;
      for (int i = 0; i < WR_MAX; i++) begin
        wbuf[i] <= 8'h00;
      end
    end else if (bits_reg == 8'h00) begin
      stage_tog_reg <= ~stage_tog_reg;
      nbyte_reg <= 5'h00;
    end else if (byte_done) begin
      if (nbyte_reg == 5'h00) begin
        cmd_reg <= rx_byte;
      end else if (nbyte_reg <= 5'(WR_MAX)) begin
        wbuf[nbyte_reg - 5'h01] <= rx_byte;
      end
      if (nbyte_reg != NBYTE_SAT) begin
        nbyte_reg <= nbyte_reg + 5'h01;
      end
    end
  end

  // Readback selection; the register file is quiet during a frame
  logic [DATA_W-1:0] data_mem [N_CH];
  logic [THR_W-1:0] thr_hi_mem [N_CH];
  logic [THR_W-1:0] thr_lo_mem [N_CH];
  logic [7:0] ccfg_mem [N_CH];
  logic [11:0] chen_reg;
  logic [11:0] incfg_reg;
  logic [7:0] setup_reg;

  wire [3:0] r_op = cmd_reg[OP_HI:OP_LO];
  wire [3:0] r_ch = cmd_reg[ADR_HI:ADR_LO];
  wire [4:0] rd_idx = bits_reg[7:3] - 5'h01;
  wire [2:0] rd_pos = 3'h7 - bits_reg[2:0];
  wire [3:0] all_ch = (rd_idx < 5'(RD_ALL_BYTES)) ? rd_idx[4:1] : 4'h0;
  wire [DATA_W-1:0] all_word = data_mem[all_ch];
  wire [7:0] all_byte = rd_idx[0] ? {all_word[1:0], 6'h00} : all_word[9:2];
  wire [3:0] sel_ch = chan_ok(r_ch) ? r_ch : 4'h0;
  wire [39:0] cfg_vec = {16'(thr_hi_mem[sel_ch]), 16'(thr_lo_mem[sel_ch]),
                         ccfg_mem[sel_ch]};
  wire [39:0] glb_vec = {4'h0, chen_reg, 4'h0, incfg_reg, setup_reg};
  wire [39:0] cfg_sh = cfg_vec << {rd_idx, 3'h0};
  wire [39:0] glb_sh = glb_vec << {rd_idx, 3'h0};
  wire rd_in5 = rd_idx < 5'(CFG_BYTES);
  wire [7:0] tx_byte =
    (r_op == OP_RD_ALL && rd_idx < 5'(RD_ALL_BYTES)) ? all_byte :
    (r_op == OP_RD_CFG && chan_ok(r_ch) && rd_in5) ? cfg_sh[39:32] :
    (r_op == OP_RD_GLB && rd_in5) ? glb_sh[39:32] : 8'h00;
  wire tx_bit = (bits_reg >= 8'h08) && tx_byte[rd_pos];

  always_ff @(negedge sclk or negedge rst_link_n) begin
    if (!rst_link_n) begin
      dout_reg <= 1'b0;
    end else begin
      dout_reg <= tx_bit;
    end
  end

  assign dout = dout_reg;

  // ---------------- System domain (clk) ----------------
  logic cs_s;
  logic tog_s;
  logic cs_prev_reg;
  logic tog_seen_reg;

  macra_sync #(.W(2)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({cs_n, stage_tog_reg}),
    .q({cs_s, tog_s})
  );

  // A frame is applied once, when select has gone high again
  wire commit = cs_s && !cs_prev_reg && (tog_s != tog_seen_reg);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs_prev_reg <= 1'b1;
      tog_seen_reg <= 1'b0;
    end else begin
      cs_prev_reg <= cs_s;
      tog_seen_reg <= (cs_s && !cs_prev_reg) ? tog_s : tog_seen_reg;
    end
  end

  wire c_has = nbyte_reg != 5'h00;
  wire [4:0] c_nd = c_has ? nbyte_reg - 5'h01 : 5'h00;
  wire [3:0] c_op = cmd_reg[OP_HI:OP_LO];
  wire [3:0] c_ch = cmd_reg[ADR_HI:ADR_LO];
  wire c_ok = chan_ok(c_ch);
  wire cm = commit && c_has;
  wire do_rst = cm && c_op == OP_RESET;
  wire wr_sel = cm && c_op == OP_WR_SEL && c_ok && c_nd >= 5'h02;
  wire wr_all = cm && c_op == OP_WR_ALL;
  wire wr_cfg = cm && c_op == OP_WR_CFG && c_ok;
  wire wr_glb = cm && c_op == OP_WR_GLB;
  wire [N_CH-1:0] ch_hot = N_CH'(1) << c_ch;
  wire [N_CH-1:0] clr_mask =
    (do_rst || (cm && c_op == OP_CLR_ALL)) ? ALARM_ALL :
    (cm && c_op == OP_CLR_SEL && c_ok) ? ch_hot :
    (wr_cfg && c_nd >= 5'h02) ? ch_hot : '0;

  assign conv_ready = cs_s && !commit;
  wire conv_take = conv_valid && conv_ready && chan_ok(conv_chan);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < N_CH; i++) begin
        data_mem[i] <= DATA_RST;
      end
    end else begin
      for (int i = 0; i < N_CH; i++) begin
        if (do_rst) begin
          data_mem[i] <= DATA_RST;
        end else if (wr_all && c_nd >= 5'(2 * i + 2)) begin
          data_mem[i] <= {wbuf[2 * i], wbuf[2 * i + 1][7:6]};
        end else if (wr_sel && c_ch == 4'(i)) begin
          data_mem[i] <= {wbuf[0], wbuf[1][7:6]};
        end else if (conv_take && conv_chan == 4'(i)) begin
          data_mem[i] <= conv_data;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < N_CH; i++) begin
        thr_hi_mem[i] <= THR_W'(THR_HI_RST);
        thr_lo_mem[i] <= THR_W'(THR_LO_RST);
        ccfg_mem[i] <= CCFG_RST;
      end
    end else begin
      for (int i = 0; i < N_CH; i++) begin
        if (do_rst) begin
          thr_hi_mem[i] <= THR_W'(THR_HI_RST);
          thr_lo_mem[i] <= THR_W'(THR_LO_RST);
          ccfg_mem[i] <= CCFG_RST;
        end else if (wr_cfg && c_ch == 4'(i)) begin
          if (c_nd >= 5'h02) begin
            thr_hi_mem[i] <= THR_W'({wbuf[0], wbuf[1]});
          end
          if (c_nd >= 5'h04) begin
            thr_lo_mem[i] <= THR_W'({wbuf[2], wbuf[3]});
          end
          if (c_nd >= 5'h05) begin
            ccfg_mem[i] <= wbuf[4];
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chen_reg <= CHEN_RST;
      incfg_reg <= INCFG_RST;
      setup_reg <= SETUP_RST;
    end else if (do_rst) begin
      chen_reg <= CHEN_RST;
      incfg_reg <= INCFG_RST;
      setup_reg <= SETUP_RST;
    end else if (wr_glb) begin
      chen_reg <= (c_nd >= 5'h02) ? {wbuf[0][3:0], wbuf[1]} : chen_reg;
      incfg_reg <= (c_nd >= 5'h04) ? {wbuf[2][3:0], wbuf[3]}
        : incfg_reg;
      setup_reg <= (c_nd >= 5'h05) ? wbuf[4] : setup_reg;
    end
  end

  logic [N_CH-1:0] alarm_clr_reg;
  logic soft_reset_reg;
  logic shutdown_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alarm_clr_reg <= '0;
      soft_reset_reg <= 1'b0;
      shutdown_reg <= 1'b0;
    end else begin
      alarm_clr_reg <= clr_mask;
      soft_reset_reg <= do_rst;
      shutdown_reg <= do_rst;
    end
  end

  assign alarm_clr = alarm_clr_reg;
  assign soft_reset = soft_reset_reg;
  assign shutdown_req = shutdown_reg;

  // Differential pairs drop the odd input's enable bit
  logic [11:0] diff_mask;
  genvar b;
  generate
    for (b = 0; b < 12; b++) begin : g_mask
      if (b >= CHEN_ODD_LO && b <= CHEN_ODD_HI && b % 2 == 0) begin : g_odd
        assign diff_mask[b] =
          incfg_reg[11 - 3 * ((CHEN_ODD_HI - b) / 2)];
      end else begin : g_keep
        assign diff_mask[b] = 1'b0;
      end
    end
  endgenerate

  // Scan set for the sequencer; manual conversions do not consult it
  assign scan_enable = chen_reg & ~diff_mask & ~CHEN_RES_MASK;
  assign chan_enable = chen_reg;
  assign input_pair_cfg = incfg_reg;
  assign setup_cfg = setup_reg;

  logic [DATA_W-1:0] look_data_reg;
  logic [THR_W-1:0] look_hi_reg;
  logic [THR_W-1:0] look_lo_reg;
  logic [7:0] look_cfg_reg;
  wire [3:0] look_ix = chan_ok(look_chan) ? look_chan : 4'h0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      look_data_reg <= DATA_RST;
      look_hi_reg <= THR_W'(THR_HI_RST);
      look_lo_reg <= THR_W'(THR_LO_RST);
      look_cfg_reg <= CCFG_RST;
    end else begin
      look_data_reg <= data_mem[look_ix];
      look_hi_reg <= thr_hi_mem[look_ix];
      look_lo_reg <= thr_lo_mem[look_ix];
      look_cfg_reg <= ccfg_mem[look_ix];
    end
  end

  assign look_data = look_data_reg;
  assign look_thr_hi = look_hi_reg;
  assign look_thr_lo = look_lo_reg;
  assign look_cfg = look_cfg_reg;

  // ---------------- Checks ----------------
  property p_reset_enable;
    @(posedge clk) disable iff (!nrst)
      do_rst |=> chen_reg == CHEN_RST && shutdown_req && soft_reset;
  endproperty
  a_reset_enable: assert property (p_reset_enable)
    else $error("reset command did not restore enables");

  property p_reset_incfg;
    @(posedge clk) disable iff (!nrst)
      do_rst |=> incfg_reg == INCFG_RST ##1 !shutdown_req;
  endproperty
  a_reset_incfg: assert property (p_reset_incfg)
    else $error("reset command did not clear input configuration");

  property p_clr_all;
    @(posedge clk) disable iff (!nrst)
      cm && c_op == OP_CLR_ALL |=> alarm_clr == ALARM_ALL;
  endproperty
  a_clr_all: assert property (p_clr_all)
    else $error("clear-all did not clear every channel");

  property p_clr_sel;
    @(posedge clk) disable iff (!nrst)
      cm && c_op == OP_CLR_SEL && c_ok |=> $onehot(alarm_clr)
        && alarm_clr == N_CH'(1) << $past(c_ch);
  endproperty
  a_clr_sel: assert property (p_clr_sel)
    else $error("clear-selected hit the wrong channel");

  property p_clr_reserved;
    @(posedge clk) disable iff (!nrst)
      cm && c_op == OP_CLR_SEL && !c_ok |=> alarm_clr == '0;
  endproperty
  a_clr_reserved: assert property (p_clr_reserved)
    else $error("reserved address cleared an alarm");

  property p_wr_sel;
    @(posedge clk) disable iff (!nrst)
      wr_sel && !conv_take |=>
        data_mem[$past(c_ch)] == {$past(wbuf[0]), $past(wbuf[1][7:6])};
  endproperty
  a_wr_sel: assert property (p_wr_sel)
    else $error("selected data write not stored");

  property p_wr_glb;
    @(posedge clk) disable iff (!nrst)
      wr_glb && c_nd >= 5'h05 |=> setup_reg == $past(wbuf[4])
        && chen_reg == {$past(wbuf[0][3:0]), $past(wbuf[1])};
  endproperty
  a_wr_glb: assert property (p_wr_glb)
    else $error("global write not stored in order");

  property p_wr_cfg_clear;
    @(posedge clk) disable iff (!nrst)
      wr_cfg && c_nd >= 5'h02 |=> alarm_clr[$past(c_ch)] ##1 alarm_clr == '0;
  endproperty
  a_wr_cfg_clear: assert property (p_wr_cfg_clear)
    else $error("configuration write did not clear the alarm");

  property p_diff_odd;
    @(posedge clk) disable iff (!nrst)
      incfg_reg[11] |-> !scan_enable[8] && scan_enable[1:0] == 2'h0;
  endproperty
  a_diff_odd: assert property (p_diff_odd)
    else $error("odd input of a differential pair still scanned");

  property p_idle_dout;
    @(posedge clk) disable iff (!nrst)
      cs_s && cs_prev_reg |-> !dout;
  endproperty
  a_idle_dout: assert property (p_idle_dout)
    else $error("serial output active with select high");

  property p_cmd_capture;
    @(posedge sclk) disable iff (!rst_link_n)
      bits_reg == CMD_LAST_BIT |=> cmd_reg == $past(rx_byte)
        && nbyte_reg == 5'h01;
  endproperty
  a_cmd_capture: assert property (p_cmd_capture)
    else $error("command word not captured on the eighth edge");
endmodule
`default_nettype wire

// *** macra_pkg.sv ***
// Constants shared by the monitor converter command and register block.
// Assumes nothing of its surroundings; imported by macra_core and tb.
`default_nettype none
package macra_pkg;
  // Channel count and transfer sizes
  localparam int N_CH = 10;
  localparam int WR_MAX = 20;
  localparam int CFG_BYTES = 5;
  localparam int RD_ALL_BYTES = 20;
  localparam int DATA_W = 10;

  // Command word fields
  localparam int OP_HI = 7;
  localparam int OP_LO = 4;
  localparam int ADR_HI = 3;
  localparam int ADR_LO = 0;
  localparam logic [7:0] BIT_CNT_SAT = 8'hFF;
  localparam logic [7:0] CMD_LAST_BIT = 8'h07;
  localparam logic [4:0] NBYTE_SAT = 5'h15;

  typedef enum logic [3:0] {
    OP_RD_ALL = 4'h3,
    OP_RD_CFG = 4'h4,
    OP_RD_GLB = 4'h5,
    OP_RESET = 4'h7,
    OP_CLR_SEL = 4'h8,
    OP_CLR_ALL = 4'h9,
    OP_WR_SEL = 4'hA,
    OP_WR_ALL = 4'hB,
    OP_WR_CFG = 4'hC,
    OP_WR_GLB = 4'hD
  } macra_op_e;

  // Highest valid channel address; above it is reserved
  localparam logic [3:0] CH_LAST = 4'h9;

  // Values after reset and after the reset command
  localparam logic [11:0] CHEN_RST = 12'hFFF;
  localparam logic [11:0] INCFG_RST = 12'h000;
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [7:0] CCFG_RST = 8'h00;
  localparam logic [15:0] THR_HI_RST = 16'h0000;
  localparam logic [15:0] THR_LO_RST = 16'h0000;
  localparam logic [9:0] DATA_RST = 10'h000;
  localparam logic [9:0] ALARM_ALL = 10'h3FF;

  // Channel-enable layout: two lowest bits reserved
  localparam logic [11:0] CHEN_RES_MASK = 12'h003;
  localparam int CHEN_ODD_LO = 2;
  localparam int CHEN_ODD_HI = 8;
endpackage
`default_nettype wire

// *** macra_sync.sv ***
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a level that changes far slower than clk.
`timescale 1ns/1ps
`default_nettype none
module macra_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  generate
    if (W < 1) begin : g_chk
      $error("macra_sync: W must be at least 1");
    end
  endgenerate

  // Reset value 1 on every bit: an idle select line is high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '1;
      q_reg <= '1;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule
`default_nettype wire

// *** macra_host.sv ***
// Host-side serial controller model for the command decoder.
// Assumes the bench calls frame after loading wr_buf; reads land in rd_buf.
`timescale 1ns/1ps
`default_nettype none
module macra_host (
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  logic [7:0] wr_buf [0:19];
  logic [7:0] rd_buf [0:19];

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // Command word, then write bits; dout is caught on every later rise
  task automatic frame(input logic [7:0] cmd, input int nbits);
    int i;
    int j;
    cs_n = 1'b0;
    #80;
    for (i = 0; i < nbits + 8; i++) begin
      j = i - 8;
      din = (i < 8) ? cmd[7 - i] : wr_buf[j / 8][7 - j % 8];
      #6 sclk = 1'b1;
      if (i >= 8)
        rd_buf[j / 8][7 - j % 8] = dout;
      #6 sclk = 1'b0;
    end
    #6 cs_n = 1'b1;
    // Released line does not keep its last value
    din = ~din;
    #100;
  endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the command decoder and its register file.
// Assumes macra_host drives the link; tb owns clk, nrst and conversions.
`timescale 1ns/1ps
`default_nettype none
module tb
  import macra_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic conv_valid = 1'b0;
  logic [3:0] conv_chan = 4'h0;
  logic [DATA_W-1:0] conv_data = 10'h000;
  logic [3:0] look_chan = 4'h0;
  wire logic sclk, cs_n, din, dout, conv_ready, soft_reset, shutdown_req;
  wire logic [DATA_W-1:0] look_data;
  wire logic [15:0] look_thr_hi, look_thr_lo;
  wire logic [7:0] look_cfg, setup_cfg;
  wire logic [11:0] chan_enable, input_pair_cfg, scan_enable;
  wire logic [N_CH-1:0] alarm_clr;
  logic [15:0] hi_m [0:10];
  logic [15:0] lo_m [0:10];
  logic [7:0] cfg_m [0:10];
  logic [9:0] dat_m [0:9];
  logic [11:0] en_m, inc_m;
  logic [7:0] set_m;
  logic [9:0] clr_acc = 10'h000;
  logic [31:0] r;
  int srst_cnt = 0, shut_cnt = 0, err_total = 0, comparisons = 0, i, ch;
  integer seed = 15;

  macra_core macra_core_i (
    .clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .conv_valid(conv_valid), .conv_chan(conv_chan),
    .conv_data(conv_data), .conv_ready(conv_ready), .look_chan(look_chan),
    .look_data(look_data), .look_thr_hi(look_thr_hi),
    .look_thr_lo(look_thr_lo), .look_cfg(look_cfg),
    .chan_enable(chan_enable), .input_pair_cfg(input_pair_cfg),
    .scan_enable(scan_enable), .setup_cfg(setup_cfg),
    .alarm_clr(alarm_clr), .soft_reset(soft_reset),
    .shutdown_req(shutdown_req)
  );
  macra_host macra_host_i (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  initial forever #10 clk = ~clk;

  // Collect one-cycle event pulses
  always @(posedge clk) begin
    clr_acc <= cs_n ? (clr_acc | alarm_clr) : 10'h000;
    srst_cnt <= srst_cnt + int'(soft_reset);
    shut_cnt <= shut_cnt + int'(shutdown_req);
  end

  function automatic logic [11:0] scan_exp(logic [11:0] en, logic [11:0] inc);
    logic [11:0] s;
    s = en & ~CHEN_RES_MASK;
    for (int p = 0; p < 4; p++)
      if (inc[11 - 3 * p])
        s[8 - 2 * p] = 1'b0;
    return s;
  endfunction

  function automatic logic [15:0] rd16(int k);
    return {macra_host_i.rd_buf[k], macra_host_i.rd_buf[k + 1]};
  endfunction

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic put16(int k, logic [15:0] v);
    macra_host_i.wr_buf[k] = v[15:8];
    macra_host_i.wr_buf[k + 1] = v[7:0];
  endtask

  task automatic go(logic [7:0] cmd, int nbits);
    macra_host_i.frame(cmd, nbits);
    repeat (2) @(negedge clk);
  endtask

  task automatic reset_model();
    for (int k = 0; k < 11; k++) begin
      hi_m[k] = THR_HI_RST;
      lo_m[k] = THR_LO_RST;
      cfg_m[k] = CCFG_RST;
      if (k < 10)
        dat_m[k] = DATA_RST;
    end
    en_m = CHEN_RST;
    inc_m = INCFG_RST;
    set_m = SETUP_RST;
  endtask

  task automatic chk_glb();
    go({4'h5, 4'($random(seed))}, 40);
    check("glb_en", rd16(0), {4'h0, en_m});
    check("glb_inc", rd16(2), {4'h0, inc_m});
    check("glb_setup", macra_host_i.rd_buf[4], set_m);
  endtask

  task automatic chk_regs();
    check("chan_enable", chan_enable, en_m);
    check("input_pair_cfg", input_pair_cfg, inc_m);
    check("setup_cfg", setup_cfg, set_m);
    check("scan_enable", scan_enable, scan_exp(en_m, inc_m));
  endtask

  task automatic chk_all();
    go({4'h3, 4'($random(seed))}, 160);
    for (int k = 0; k < 10; k++)
      check("data", rd16(2 * k), {dat_m[k], 6'h00});
  endtask

  initial begin
    reset_model();
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(negedge clk);
    check("en_rst", chan_enable, CHEN_RST);
    check("inc_rst", input_pair_cfg, INCFG_RST);
    check("scan_rst", scan_enable, 12'hFFC);
    chk_glb();
    // Global writes; first one makes every pair differential
    for (i = 0; i < 5; i++) begin
      r = $random(seed);
      en_m = r[11:0];
      inc_m = (i == 0) ? 12'h9A4 : r[23:12];
      set_m = r[31:24];
      put16(0, {r[15:12], en_m});
      put16(2, {4'h0, inc_m});
      macra_host_i.wr_buf[4] = set_m;
      go({4'hD, 4'(i)}, 40);
      chk_regs();
      chk_glb();
    end
    for (ch = 0; ch < 10; ch++) begin
      r = $random(seed);
      hi_m[ch] = r[15:0];
      lo_m[ch] = r[31:16];
      cfg_m[ch] = 8'($random(seed));
      put16(0, hi_m[ch]);
      put16(2, lo_m[ch]);
      macra_host_i.wr_buf[4] = cfg_m[ch];
      go({4'hC, 4'(ch)}, 40);
      check("cfg_clr", clr_acc, 10'h001 << ch);
    end
    put16(0, 16'hA5A5);
    go(8'hCB, 40);
    check("rsv_clr", clr_acc, 10'h000);
    for (ch = 0; ch < 11; ch++) begin
      go({4'h4, 4'(ch)}, 40);
      check("thr_hi", rd16(0), hi_m[ch]);
      check("thr_lo", rd16(2), lo_m[ch]);
      check("ch_cfg", macra_host_i.rd_buf[4], cfg_m[ch]);
      @(posedge clk);
      look_chan <= 4'(ch);
      repeat (2) @(negedge clk);
      // Reserved lookup addresses fall back to channel 0
      i = (ch < 10) ? ch : 0;
      check("look_thr", look_thr_hi, hi_m[i]);
      check("look_lo", look_thr_lo, lo_m[i]);
      check("look_cfg", look_cfg, cfg_m[i]);
    end
    for (ch = 0; ch < 11; ch++) begin
      go({4'h8, 4'(ch)}, 0);
      check("clr_sel", clr_acc, (ch < 10) ? 1 << ch : 0);
    end
    go(8'h96, 0);
    check("clr_all", clr_acc, ALARM_ALL);
    for (i = 0; i < 10; i++) begin
      dat_m[i] = 10'($random(seed));
      put16(2 * i, {dat_m[i], 6'($random(seed))});
    end
    go(8'hB5, 160);
    chk_all();
    for (ch = 0; ch < 10; ch += 9) begin
      dat_m[ch] = 10'($random(seed));
      put16(0, {dat_m[ch], 6'h3F});
      go({4'hA, 4'(ch)}, 16);
    end
    go(8'hAD, 16);
    chk_all();
    // A conversion result lands between frames
    for (i = 0; i < 50 && conv_ready !== 1'b1; i++)
      @(negedge clk);
    check("conv_ready", conv_ready, 1'b1);
    if (conv_ready !== 1'b1)
      report_and_stop();
    @(posedge clk);
    conv_valid <= 1'b1;
    conv_chan <= 4'h5;
    conv_data <= 10'($random(seed));
    @(posedge clk);
    conv_valid <= 1'b0;
    look_chan <= 4'h5;
    dat_m[5] = conv_data;
    repeat (2) @(negedge clk);
    check("look_data", look_data, dat_m[5]);
    chk_all();
    put16(0, 16'h0ABC);
    put16(2, 16'h0123);
    go(8'hE3, 40);
    chk_regs();
    go(8'hD0, 21);
    en_m = 12'hABC;
    chk_regs();
    chk_glb();
    i = srst_cnt;
    ch = shut_cnt;
    go(8'h7A, 0);
    check("soft_reset", srst_cnt - i, 1);
    check("shutdown", shut_cnt - ch, 1);
    check("rst_clr", clr_acc, ALARM_ALL);
    reset_model();
    chk_regs();
    chk_all();
    report_and_stop();
  end
endmodule
`default_nettype wire
